// *** hdl/program_space_data_window.sv ***
`timescale 1ns/1ps
// Overview of operation
// - upper data half maps onto program page
// - map when address msb and enable set
// - eight-bit page selects one of 256
// - program address is page then offset
// - low 15 address bits pass straight through
// - mapped read costs two program fetches
// - return only low 16 word bits
// - table operations suspend the window
// - move outside loop costs one cycle
// - other instructions outside loop cost two
// - loop edges and interrupts cost two
// - other loop iterations cost nothing extra
module program_space_data_window (
   input  wire logic                         sys_clk,       // system clock
   input  wire logic                         srst,          // sync reset, high
   input  wire logic [3:0]                   reg_addr,      // register address
   input  wire logic [15:0]                  reg_wdata,     // register write data
   input  wire logic                         reg_wr,        // register write strobe
   input  wire logic                         reg_rd,        // register read strobe
   output logic      [15:0]                  reg_rdata,     // read data, next cycle
   input  wire logic                         cpu_rd,        // data read request pulse
   input  wire logic [win_pkg::DADDR_W-1:0]  cpu_addr,      // effective data address
   input  wire logic                         cpu_move,      // transfer instr
   input  wire logic                         cpu_in_loop,   // inside repeat loop
   input  wire logic                         cpu_loop_first,// first iteration
   input  wire logic                         cpu_loop_last, // last iteration
   input  wire logic                         cpu_irq_out,   // leaving for interrupt
   input  wire logic                         cpu_irq_back,  // back from interrupt
   input  wire logic                         table_busy,    // table read/write active
   output logic                              cpu_valid,     // read data valid pulse
   output logic      [win_pkg::DATA_W-1:0]   cpu_rdata,     // read data
   output logic      [1:0]                   cpu_extra,     // extra cycles of access
   output logic                              cpu_busy,      // windowed access in progress
   output logic                              pm_rd,         // program memory read
   output logic      [win_pkg::PADDR_W-1:0]  pm_addr,       // program memory address
   input  wire logic [win_pkg::PWORD_W-1:0]  pm_rdata,      // program word, next cycle
   output logic                              dm_rd,         // data memory read
   output logic      [win_pkg::DADDR_W-1:0]  dm_addr,       // data memory address
   input  wire logic [win_pkg::DATA_W-1:0]   dm_rdata       // data word, next cycle
);
   import win_pkg::*;

   // ------------------------------------------------------------
   // state and helper signals
   // ------------------------------------------------------------
   logic [PAGE_W-1:0]  page_r;         // window page select
   logic               en_r;           // program window enable
   logic               hit_page;       // address selects page register
   logic               hit_ctrl;       // address selects core control
   logic               hit_status;     // address selects status
   logic               seq_idle;       // sequencer free for a request
   logic               seq_fetch;      // sequencer issues second fetch
   logic               seq_done;       // sequencer releases the core
   logic               take;           // request accepted this cycle
   logic               addr_upper;     // address in upper data half
   logic               mapped;         // current request goes to the window
   logic               win_take;       // accepted request, windowed
   logic               plain_take;     // accepted request, data memory
   logic [1:0]         extra_nxt;      // cost of current request
   logic [OFFS_W-1:0]  win_offs;       // offset inside the page
   logic [PADDR_W-1:0] pm_addr_nxt;    // program address of current request
   logic               fetch2_r;       // program word stands this cycle
   logic               dm_pend_r;      // data memory answer due
   logic [7:0]         win_cnt_r;      // windowed access count
   logic [15:0]        page_word;      // page register as read back
   logic [15:0]        ctrl_word;      // core control as read back
   logic [15:0]        status_word;    // status as read back
   seq_state_t         state_r;        // access sequencer state
   seq_state_t         state_nxt;      // next sequencer state

   // ------------------------------------------------------------
   // register address decode
   // ------------------------------------------------------------
   // one hit per implemented register
   always_comb begin
      hit_page   = 1'b0;
      hit_ctrl   = 1'b0;
      hit_status = 1'b0;
      if (reg_addr == ADDR_PAGE) begin
         hit_page = 1'b1;
      end else if (reg_addr == ADDR_CORE_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (reg_addr == ADDR_STATUS) begin
         hit_status = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // page register, takes the low byte
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         page_r <= PAGE_RESET;
      end else if (reg_wr && hit_page) begin
         page_r <= reg_wdata[PAGE_W-1:0];
      end
   end

   // window enable bit in core control
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         en_r <= EN_RESET;
      end else if (reg_wr && hit_ctrl) begin
         en_r <= reg_wdata[CTRL_EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // register read back
   // ------------------------------------------------------------
   // page image, upper byte reads zero
   assign page_word = {8'h00, page_r};

   // core control image, only the enable bit exists
   always_comb begin
      // all other bits read as zero
      ctrl_word              = 16'h0000;
      ctrl_word[CTRL_EN_BIT] = en_r;
   end

   // status image: count, table activity, busy, enable
   assign status_word = {win_cnt_r, 5'h00, table_busy, cpu_busy, en_r};

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else if (hit_page) begin
         reg_rdata <= page_word;
      end else if (hit_ctrl) begin
         reg_rdata <= ctrl_word;
      end else if (hit_status) begin
         reg_rdata <= status_word;
      end else begin
         // unused addresses read as zero
         reg_rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   // sequencer state flags
   assign seq_idle  = (state_r == ST_IDLE);
   assign seq_fetch = (state_r == ST_FETCH);
   assign seq_done  = (state_r == ST_DONE);

   // requests are only taken while the sequencer is idle
   assign take = cpu_rd && seq_idle;

   assign addr_upper = cpu_addr[DADDR_W-1];

   assign mapped = addr_upper && en_r && !table_busy;

   assign win_take   = take && mapped;
   assign plain_take = take && !mapped;

   assign win_offs = cpu_addr[OFFS_W-1:0];

   assign pm_addr_nxt = {page_r, win_offs};

   // cost of the access from the instruction context
   window_cost u_cost (
      .mapped        (mapped),
      .is_move       (cpu_move),
      .in_loop       (cpu_in_loop),
      .loop_first    (cpu_loop_first),
      .loop_last     (cpu_loop_last),
      .loop_irq_out  (cpu_irq_out),
      .loop_irq_back (cpu_irq_back),
      .extra         (extra_nxt)
   );

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   // windowed read: first fetch, second fetch, answer, release
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (win_take) begin
               state_nxt = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            // word stands on the bus now
            state_nxt = ST_DONE;
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            // stray codes fall back to idle
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pm_rd <= 1'b0;
      end else begin
         pm_rd <= win_take || seq_fetch;
      end
   end

   // program address held for both fetches
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pm_addr <= '0;
      end else if (win_take) begin
         pm_addr <= pm_addr_nxt;
      end
   end

   // marks the cycle in which the word stands
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fetch2_r <= 1'b0;
      end else begin
         fetch2_r <= seq_fetch;
      end
   end

   // cost stands from acceptance to the next request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpu_extra <= XTRA_NONE;
      end else if (win_take) begin
         cpu_extra <= extra_nxt;
      end else if (plain_take) begin
         cpu_extra <= XTRA_NONE;
      end
   end

   // busy covers the whole windowed access
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpu_busy <= 1'b0;
      end else if (win_take) begin
         cpu_busy <= 1'b1;
      end else if (seq_done) begin
         cpu_busy <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // data memory path
   // ------------------------------------------------------------
   // one strobe per plain request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dm_rd <= 1'b0;
      end else begin
         dm_rd <= plain_take;
      end
   end

   // address captured with the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dm_addr <= '0;
      end else if (plain_take) begin
         dm_addr <= cpu_addr;
      end
   end

   // memory answers the cycle after its strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dm_pend_r <= 1'b0;
      end else begin
         dm_pend_r <= dm_rd;
      end
   end

   // ------------------------------------------------------------
   // answer back to the core
   // ------------------------------------------------------------
   // one valid pulse per request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpu_valid <= 1'b0;
      end else begin
         cpu_valid <= fetch2_r || dm_pend_r;
      end
   end

   // read data held until the next answer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpu_rdata <= '0;
      end else if (fetch2_r) begin
         cpu_rdata <= pm_rdata[DATA_W-1:0];
      end else if (dm_pend_r) begin
         cpu_rdata <= dm_rdata;
      end
   end

   // ------------------------------------------------------------
   // status counter
   // ------------------------------------------------------------
   // counts finished windowed reads, wraps
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         win_cnt_r <= 8'h00;
      end else if (seq_done) begin
         win_cnt_r <= win_cnt_r + 8'h01;
      end
   end
endmodule

// *** hdl/psv_cost.sv ***
`timescale 1ns/1ps
// works out the extra cycles one windowed access costs
module window_cost (
   input  wire logic       mapped,        // access goes through the window
   input  wire logic       is_move,       // single or double transfer instr
   input  wire logic       in_loop,       // inside a hardware repeat loop
   input  wire logic       loop_first,    // first iteration
   input  wire logic       loop_last,     // last iteration
   input  wire logic       loop_irq_out,  // iteration cut short by interrupt
   input  wire logic       loop_irq_back, // first iteration after return
   output logic      [1:0] extra          // extra cycles to add
);
   import win_pkg::*;

   // cost selection by context
   always_comb begin
      extra = XTRA_NONE;
      if (mapped) begin
         if (in_loop) begin
            if (loop_first || loop_last || loop_irq_out || loop_irq_back) begin
               extra = XTRA_OTHER;
            end else begin
               extra = XTRA_NONE;
            end
         end else if (is_move) begin
            extra = XTRA_MOVE;
         end else begin
            extra = XTRA_OTHER;
         end
      end
   end
endmodule

// *** hdl/psv_pkg.sv ***
package win_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_PAGE      = 4'h0;   // window page select
   localparam logic [3:0] ADDR_CORE_CTRL = 4'h1;   // cpu core control
   localparam logic [3:0] ADDR_STATUS    = 4'h2;   // block status
   localparam int         CTRL_EN_BIT    = 2;      // window enable bit position
   localparam logic [7:0] PAGE_RESET     = 8'h00;
   localparam logic       EN_RESET       = 1'b0;

   // ------------------------------------------------------------
   // address layout
   // ------------------------------------------------------------
   localparam int DADDR_W   = 16;                  // data address width
   localparam int OFFS_W    = 15;                  // low data address bits used
   localparam int PAGE_W    = 8;                   // page register width
   localparam int PADDR_W   = PAGE_W + OFFS_W;     // program address width
   localparam int PWORD_W   = 24;                  // program word width
   localparam int DATA_W    = 16;                  // data word width

   // ------------------------------------------------------------
   // extra cycle counts
   // ------------------------------------------------------------
   localparam logic [1:0] XTRA_NONE  = 2'h0;
   localparam logic [1:0] XTRA_MOVE  = 2'h1;       // move outside loop
   localparam logic [1:0] XTRA_OTHER = 2'h2;       // other instr, or loop edge

   // ------------------------------------------------------------
   // access sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_DONE  = 4'b1000
   } seq_state_t;
endpackage

// *** tb/program_space_data_window_tb.sv ***
`timescale 1ns/1ps
module program_space_data_window_tb;
   import win_pkg::*;
   logic        sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, cpu_rd = 1'h0;
   logic [6:0]  fl = 7'h00; // table, move, loop, first, last, irq out, irq back
   wire         table_busy = fl[6], cpu_move = fl[5], cpu_in_loop = fl[4];
   wire         cpu_loop_first = fl[3], cpu_loop_last = fl[2], cpu_irq_out = fl[1];
   wire         cpu_irq_back = fl[0];
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, cpu_addr = 16'h0000;
   logic [15:0] reg_rdata, cpu_rdata, dm_addr, dm_rdata;
   logic        cpu_valid, cpu_busy, pm_rd, dm_rd;
   logic [1:0]  cpu_extra;
   logic [22:0] pm_addr;
   logic [23:0] pm_rdata;
   // cost cases: flags then expected extra
   logic [7:0]  tbl [9] = '{8'h81, 8'h02, 8'h62, 8'h52, 8'h4A, 8'h46, 8'h40, 8'hC0, 8'hE2};
   int          errors = 0, n_compared = 0, cycles = 0;
   program_space_data_window dut (.*);
   far_mem_model mem (.*);
   // clock and hang guard
   initial forever #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 1500) begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one register cycle, read data checked the cycle after
   task automatic reg_xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      @(negedge sys_clk);
      if (!wr) chk("reg_rdata", d, reg_rdata);
   endtask
   // one data read, answer awaited and compared
   task automatic cpu_xfer(input logic [15:0] a, input logic [6:0] f, input logic [15:0] exp,
                           input logic [1:0] xtra);
      @(posedge sys_clk);
      cpu_rd <= 1'h1;
      cpu_addr <= a;
      fl <= f;
      @(posedge sys_clk);
      cpu_rd <= 1'h0;
      for (int k = 0; k < 6 && cpu_valid !== 1'h1; k++) @(negedge sys_clk);
      chk("cpu_valid", 16'h0001, {15'h0000, cpu_valid});
      chk("cpu_rdata", exp, cpu_rdata);
      chk("cpu_extra", {14'h0, xtra}, {14'h0, cpu_extra});
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      logic [15:0] a;
      repeat (16) @(posedge sys_clk);
      srst <= 1'h0;
      reg_xfer(1'h0, ADDR_PAGE, 16'h0000);
      reg_xfer(1'h0, ADDR_CORE_CTRL, 16'h0000);
      reg_xfer(1'h1, 4'hF, 16'hFFFF);
      reg_xfer(1'h0, 4'hF, 16'h0000);
      cpu_xfer(16'h9234, 7'h20, ~16'h9234, XTRA_NONE);
      reg_xfer(1'h1, ADDR_PAGE, 16'h00A5);
      reg_xfer(1'h0, ADDR_PAGE, 16'h00A5);
      reg_xfer(1'h1, ADDR_CORE_CTRL, 16'h0004);
      reg_xfer(1'h0, ADDR_CORE_CTRL, 16'h0004);
      for (int i = 0; i < 9; i++) begin
         a = 16'h8000 | 16'(i * 16'h1C47);
         cpu_xfer(a, {1'h0, tbl[i][7:2]}, {8'hA5 ^ a[7:0], a[14:7]}, tbl[i][1:0]);
      end
      reg_xfer(1'h1, ADDR_PAGE, 16'h00FF);
      cpu_xfer(16'hFFFF, 7'h00, 16'h00FF, XTRA_OTHER);
      cpu_xfer(16'h7FFF, 7'h20, ~16'h7FFF, XTRA_NONE);
      cpu_xfer(16'hC000, 7'h40, ~16'hC000, XTRA_NONE);
      cpu_xfer(16'hC000, 7'h20, 16'hFF80, XTRA_MOVE);
      reg_xfer(1'h0, ADDR_STATUS, 16'h0B01);
      close_out();
   end
endmodule
bind program_space_data_window window_chk watch (.*);

// *** tb/psv_far_mem.sv ***
`timescale 1ns/1ps
// program and data memory behind the window
module far_mem_model (
   input  logic        sys_clk,  // clock
   input  logic        pm_rd,    // pm strobe
   input  logic [22:0] pm_addr,  // pm address
   output logic [23:0] pm_rdata, // pm word
   input  logic        dm_rd,    // dm strobe
   input  logic [15:0] dm_addr,  // dm address
   output logic [15:0] dm_rdata  // dm word
);
   // answer a cycle after the strobe, garble when idle
   always_ff @(posedge sys_clk) begin
      pm_rdata <= pm_rd ? {pm_addr[7:0], pm_addr[22:15] ^ pm_addr[7:0], pm_addr[14:7]}
                        : ~pm_rdata;
      dm_rdata <= dm_rd ? ~dm_addr : ~dm_rdata;
   end
endmodule

// *** tb/psv_window_assertions.sv ***
`timescale 1ns/1ps
// port checks on the window block
module window_chk (
   input logic        sys_clk,        // clock
   input logic        srst,           // reset
   input logic        cpu_rd,         // request
   input logic [15:0] cpu_addr,       // address
   input logic        cpu_move,       // move
   input logic        cpu_in_loop,    // loop
   input logic        cpu_loop_first, // first
   input logic        cpu_loop_last,  // last
   input logic        cpu_irq_out,    // irq out
   input logic        cpu_irq_back,   // irq back
   input logic        table_busy,     // table op
   input logic        cpu_valid,      // answer
   input logic [15:0] cpu_rdata,      // data
   input logic [1:0]  cpu_extra,      // cost
   input logic        cpu_busy,       // busy
   input logic        pm_rd,          // pm read
   input logic [22:0] pm_addr,        // pm addr
   input logic [23:0] pm_rdata,       // pm word
   input logic        dm_rd           // dm read
);
   import win_pkg::*;
   // accepted request, loop edge iteration
   wire take = cpu_rd && !cpu_busy;
   wire rim = cpu_loop_first || cpu_loop_last || cpu_irq_out || cpu_irq_back;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_map; take ##1 pm_rd; endsequence
   property p_pm_addr; s_map |-> pm_addr[14:0] == 15'($past(cpu_addr)); endproperty
   a_pm_addr: assert property (p_pm_addr) else $error("bad pm address");
   property p_fetch; s_map |=> pm_rd ##1 (!pm_rd && cpu_valid) ##1 !cpu_busy; endproperty
   a_fetch: assert property (p_fetch) else $error("bad fetch pair");
   property p_low; s_map |-> ##2 cpu_rdata == 16'($past(pm_rdata)); endproperty
   a_low: assert property (p_low) else $error("bad word half");
   property p_plain; take && !cpu_addr[15] |=> dm_rd && !pm_rd; endproperty
   a_plain: assert property (p_plain) else $error("low half mapped");
   property p_table; take && table_busy |=> dm_rd && cpu_extra == XTRA_NONE; endproperty
   a_table: assert property (p_table) else $error("window not off");
   property p_move;
      take && cpu_move && !cpu_in_loop ##1 pm_rd |-> cpu_extra == XTRA_MOVE;
   endproperty
   a_move: assert property (p_move) else $error("bad move cost");
   property p_other;
      take && !cpu_move && !cpu_in_loop ##1 pm_rd |-> cpu_extra == XTRA_OTHER;
   endproperty
   a_other: assert property (p_other) else $error("bad other cost");
   property p_rim; take && cpu_in_loop && rim ##1 pm_rd |-> cpu_extra == XTRA_OTHER; endproperty
   a_rim: assert property (p_rim) else $error("bad loop edge cost");
   property p_mid; take && cpu_in_loop && !rim ##1 pm_rd |-> cpu_extra == XTRA_NONE; endproperty
   a_mid: assert property (p_mid) else $error("bad loop cost");
   cover property (s_map ##2 cpu_valid);
   cover property (take && table_busy);
   cover property (take && cpu_in_loop);
endmodule
